// File: src/afc_codec.sv
module afc_codec (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready
);

  // =====================================================================
  // state
  typedef enum logic [6:0] {
    ST_SEARCH = 7'b0000001,
    ST_LEN_HI = 7'b0000010,
    ST_LEN_LO = 7'b0000100,
    ST_BODY   = 7'b0001000,
    ST_CKSUM  = 7'b0010000,
    ST_WAIT   = 7'b0100000,
    ST_SEND   = 7'b1000000
  } afc_state_t;

  afc_state_t          st_r;
  logic [15:0]         len_r;
  logic [15:0]         bidx_r;
  logic [7:0]          sum_r;
  logic                esc_pend_r;
  logic [7:0]          type_r;
  logic [7:0]          fid_r;
  logic [63:0]         dest_r;
  logic [7:0]          opts_r;
  logic [15:0]         cmd_r;
  logic [31:0]         pval_r;
  logic                rx_ready_r;
  logic [1:0]          esc_mode_r;
  logic [7:0]          txs_code_r;
  logic [7:0]          cnt_good_r;
  logic [7:0]          cnt_cks_r;
  logic [7:0]          cnt_type_r;
  afc_pkg::afc_txreq_t txreq_r;
  logic [7:0]          rtype_r;
  logic [7:0]          rfid_r;
  logic [15:0]         rcmd_r;
  logic [7:0]          rstat_r;
  logic [3:0]          rlen_r;
  logic [31:0]         rval_r;
  logic [3:0]          ridx_r;
  logic [7:0]          rsum_r;
  logic [31:0]         prdata_r;
  logic                pready_r;
  logic                pslverr_r;

  // =====================================================================
  // receive byte decode
  logic        rx_take;
  logic        esc_on;
  logic        is_delim;
  logic        is_mark;
  logic        byte_ok;
  logic [7:0]  rx_b;
  logic        frame_done;
  logic        cks_ok;
  logic        typ_tx;
  logic        typ_cmd;
  logic        has_param;
  logic        wants_resp;
  logic [7:0]  esc_in_data;
  logic        esc_in_ready;
  logic [3:0]  kidx;

  assign rx_take  = clk_en && rx_valid && rx_ready_r;
  assign esc_on   = esc_mode_r == afc_pkg::ESC_MODE_ON;
  // an unescaped delimiter always restarts in escaped mode; otherwise only while searching
  assign is_delim = rx_data == afc_pkg::DELIM && (esc_on || st_r == ST_SEARCH);
  assign is_mark  = esc_on && !esc_pend_r && rx_data == afc_pkg::ESC_MARK;
  assign rx_b     = esc_pend_r ? (rx_data ^ afc_pkg::ESC_XOR) : rx_data;
  // anything outside a frame is silently dropped
  assign byte_ok  = rx_take && !is_delim && !is_mark && st_r != ST_SEARCH;

  assign frame_done = byte_ok && st_r == ST_CKSUM;
  assign cks_ok     = 8'(sum_r + rx_b) == afc_pkg::CKSUM_BASE;
  // an empty frame carries no type byte, so the stale one must not count
  assign typ_tx     = type_r == afc_pkg::TYPE_TX64 && len_r != 16'h0000;
  assign typ_cmd    = type_r == afc_pkg::TYPE_CMD && len_r != 16'h0000;
  assign has_param  = len_r > afc_pkg::QUERY_LEN;
  assign wants_resp = cks_ok && (typ_tx || typ_cmd) && fid_r != 8'h00;

  // =====================================================================
  // parser and response sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r       <= ST_SEARCH;
      len_r      <= 16'h0000;
      bidx_r     <= 16'h0000;
      sum_r      <= 8'h00;
      esc_pend_r <= 1'b0;
      rx_ready_r <= 1'b1;
      ridx_r     <= 4'h0;
      rsum_r     <= 8'h00;
    end else if (clk_en) begin
      if (rx_take && is_delim) begin
        st_r       <= ST_LEN_HI;
        esc_pend_r <= 1'b0;
        sum_r      <= 8'h00;
      end else if (rx_take && is_mark) begin
        esc_pend_r <= 1'b1;
      end else if (byte_ok) begin
        esc_pend_r <= 1'b0;
        case (st_r)
          ST_LEN_HI: begin
            len_r[15:8] <= rx_b;
            st_r        <= ST_LEN_LO;
          end
          ST_LEN_LO: begin
            len_r[7:0] <= rx_b;
            bidx_r     <= 16'h0000;
            st_r       <= ({len_r[15:8], rx_b} == 16'h0000) ? ST_CKSUM : ST_BODY;
          end
          ST_BODY: begin
            sum_r  <= 8'(sum_r + rx_b);
            bidx_r <= 16'(bidx_r + 16'h0001);
            if (bidx_r == 16'(len_r - 16'h0001)) begin
              st_r <= ST_CKSUM;
            end
          end
          ST_CKSUM: begin
            st_r       <= wants_resp ? ST_WAIT : ST_SEARCH;
            rx_ready_r <= !wants_resp;
          end
          default: st_r <= ST_SEARCH;
        endcase
      end else if (st_r == ST_WAIT) begin
        st_r   <= ST_SEND;
        ridx_r <= 4'h0;
        rsum_r <= 8'h00;
      end else if (st_r == ST_SEND && esc_in_ready) begin
        ridx_r <= 4'(ridx_r + 4'h1);
        if (ridx_r >= 4'h3) begin
          rsum_r <= 8'(rsum_r + esc_in_data);
        end
        if (ridx_r == 4'(rlen_r + 4'h3)) begin
          st_r       <= ST_SEARCH;
          rx_ready_r <= 1'b1;
        end
      end
    end
  end

  // field capture, most significant byte first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      type_r <= 8'h00;
      fid_r  <= 8'h00;
      dest_r <= 64'h0;
      opts_r <= 8'h00;
      cmd_r  <= 16'h0000;
      pval_r <= 32'h0;
    end else if (clk_en && rx_take && is_delim) begin
      // a frame too short to carry an id must never be answered
      fid_r <= 8'h00;
    end else if (clk_en && byte_ok && st_r == ST_BODY) begin
      if (bidx_r == 16'h0000) begin
        type_r <= rx_b;
      end
      if (bidx_r == afc_pkg::BI_FID) begin
        fid_r <= rx_b;
      end
      if (bidx_r >= afc_pkg::BI_CMD_HI && bidx_r <= afc_pkg::BI_DEST_LAST) begin
        dest_r <= {dest_r[55:0], rx_b};
      end
      if (bidx_r == afc_pkg::BI_CMD_HI || bidx_r == afc_pkg::BI_CMD_LO) begin
        cmd_r <= {cmd_r[7:0], rx_b};
      end
      if (bidx_r == afc_pkg::BI_OPTS) begin
        opts_r <= rx_b;
      end
      if (bidx_r >= afc_pkg::BI_PARAM) begin
        // only the last four parameter bytes are kept
        pval_r <= {pval_r[23:0], rx_b};
      end
    end
  end

  // =====================================================================
  // parameter store and immediate apply
  afc_pkg::afc_memwr_t pm_wr;
  logic [31:0]         pm_rd;
  logic                param_set;

  assign param_set  = frame_done && cks_ok && typ_cmd && has_param;
  assign pm_wr.en   = param_set;
  assign pm_wr.addr = cmd_r[afc_pkg::PMEM_AW-1:0];
  assign pm_wr.data = pval_r;

  afc_param_mem u_pmem (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .wr      (pm_wr),
    .rd_addr (cmd_r[afc_pkg::PMEM_AW-1:0]),
    .rd_data (pm_rd)
  );

  // response fields; the reply value is latched during the wait cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtype_r <= 8'h00;
      rfid_r  <= 8'h00;
      rcmd_r  <= 16'h0000;
      rstat_r <= 8'h00;
      rlen_r  <= 4'h0;
      rval_r  <= 32'h0;
    end else if (clk_en) begin
      if (frame_done && wants_resp) begin
        rfid_r  <= fid_r;
        rcmd_r  <= cmd_r;
        rtype_r <= typ_tx ? afc_pkg::TYPE_TX_STAT : afc_pkg::TYPE_CMD_RSP;
        rstat_r <= typ_tx ? txs_code_r : 8'h00;
        rlen_r  <= typ_tx ? afc_pkg::RLEN_TX_STAT
                 : (has_param ? afc_pkg::RLEN_SET : afc_pkg::RLEN_QUERY);
      end
      if (st_r == ST_WAIT) begin
        case (rcmd_r)
          afc_pkg::CMD_MAX_PAYLOAD: rval_r <= afc_pkg::MAX_PAYLOAD;
          afc_pkg::CMD_ESC_MODE:    rval_r <= {30'h0, esc_mode_r};
          default:                  rval_r <= pm_rd;
        endcase
      end
    end
  end

  // =====================================================================
  // response byte builder feeding the escaper
  assign kidx = 4'(ridx_r - 4'h3);

  always_comb begin
    esc_in_data = 8'h00;
    if (ridx_r == 4'h0) begin
      esc_in_data = afc_pkg::DELIM;
    end else if (ridx_r == 4'h2) begin
      esc_in_data = {4'h0, rlen_r};
    end else if (ridx_r == 4'(rlen_r + 4'h3)) begin
      esc_in_data = 8'(afc_pkg::CKSUM_BASE - rsum_r);
    end else if (ridx_r >= 4'h3) begin
      case (kidx)
        4'h0:    esc_in_data = rtype_r;
        4'h1:    esc_in_data = rfid_r;
        4'h2:    esc_in_data = (rlen_r == afc_pkg::RLEN_TX_STAT) ? rstat_r : rcmd_r[15:8];
        4'h3:    esc_in_data = rcmd_r[7:0];
        4'h4:    esc_in_data = rstat_r;
        4'h5:    esc_in_data = rval_r[31:24];
        4'h6:    esc_in_data = rval_r[23:16];
        4'h7:    esc_in_data = rval_r[15:8];
        default: esc_in_data = rval_r[7:0];
      endcase
    end
  end

  afc_tx_escaper u_esc (
    .pclk        (pclk),
    .presetn     (presetn),
    .clk_en      (clk_en),
    .esc_on      (esc_on),
    .in_data     (esc_in_data),
    .in_first    (ridx_r == 4'h0),
    .in_valid    (st_r == ST_SEND),
    .in_ready    (esc_in_ready),
    .out_data_r  (tx_data),
    .out_valid_r (tx_valid),
    .out_ready   (tx_ready)
  );

  // =====================================================================
  // frame statistics and last transmit request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_good_r <= 8'h00;
      cnt_cks_r  <= 8'h00;
      cnt_type_r <= 8'h00;
      txreq_r    <= '0;
    end else if (clk_en && frame_done) begin
      if (!cks_ok) begin
        cnt_cks_r <= 8'(cnt_cks_r + 8'h01);
      end else if (!(typ_tx || typ_cmd)) begin
        cnt_type_r <= 8'(cnt_type_r + 8'h01);
      end else begin
        cnt_good_r <= 8'(cnt_good_r + 8'h01);
      end
      if (cks_ok && typ_tx) begin
        txreq_r.dest <= dest_r;
        txreq_r.opts <= opts_r;
        txreq_r.plen <= (len_r > afc_pkg::BI_PAYLOAD) ? 16'(len_r - afc_pkg::BI_PAYLOAD)
                                                     : 16'h0000;
      end
    end
  end

  // =====================================================================
  // apb slave: one access cycle, answer registered in the setup cycle
  logic setup_ph;
  logic wr_go;

  assign setup_ph = psel && !penable && !pready_r;
  assign wr_go    = psel && penable && pready_r && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else if (clk_en) begin
      pready_r  <= setup_ph;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
      if (setup_ph) begin
        case (paddr)
          afc_pkg::REG_CTRL:    prdata_r <= {16'h0, txs_code_r, 6'h0, esc_mode_r};
          afc_pkg::REG_STAT:    prdata_r <= {8'h0, cnt_type_r, cnt_cks_r, cnt_good_r};
          afc_pkg::REG_DEST_HI: prdata_r <= txreq_r.dest[63:32];
          afc_pkg::REG_DEST_LO: prdata_r <= txreq_r.dest[31:0];
          afc_pkg::REG_TXINFO:  prdata_r <= {txreq_r.plen, 5'h0,
                                             txreq_r.opts[afc_pkg::OPT_BCAST_PAN],
                                             txreq_r.opts[afc_pkg::OPT_NO_ACK],
                                             txreq_r.dest == afc_pkg::BCAST_ADDR,
                                             txreq_r.opts};
          default:              pslverr_r <= 1'b1;
        endcase
      end
    end
  end

  // escaped mode changes from software or from a local command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      esc_mode_r <= afc_pkg::CTRL_ESC_RST;
      txs_code_r <= afc_pkg::CTRL_TXS_RST;
    end else if (clk_en) begin
      if (param_set && cmd_r == afc_pkg::CMD_ESC_MODE) begin
        esc_mode_r <= pval_r[1:0];
      end else if (wr_go && paddr == afc_pkg::REG_CTRL) begin
        esc_mode_r <= pwdata[1:0];
      end
      if (wr_go && paddr == afc_pkg::REG_CTRL) begin
        txs_code_r <= pwdata[15:8];
      end
    end
  end

  assign prdata   = prdata_r;
  assign pready   = pready_r;
  assign pslverr  = pslverr_r;
  assign rx_ready = rx_ready_r;

  // =====================================================================
  a_delim_start: assert property (@(posedge pclk) disable iff (!presetn)
    rx_take && st_r == ST_SEARCH && rx_data == afc_pkg::DELIM |=> st_r == ST_LEN_HI)
    else $error("delimiter did not open a frame");
  a_bad_cks_drop: assert property (@(posedge pclk) disable iff (!presetn)
    frame_done && !cks_ok |=> st_r == ST_SEARCH && cnt_cks_r == 8'($past(cnt_cks_r) + 8'h01))
    else $error("bad checksum frame not dropped");
  a_fid_zero_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    frame_done && fid_r == 8'h00 |=> st_r == ST_SEARCH ##1 !tx_valid)
    else $error("response emitted for frame id zero");
  a_resp_fid_copy: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == ST_SEND && ridx_r == 4'h4 |-> esc_in_data == rfid_r)
    else $error("response frame id differs from request");
  a_tx_stat_type: assert property (@(posedge pclk) disable iff (!presetn)
    frame_done && wants_resp && typ_tx |=> rtype_r == afc_pkg::TYPE_TX_STAT ##1 st_r == ST_SEND)
    else $error("transmit request not answered with status");
  a_cmd_resp_type: assert property (@(posedge pclk) disable iff (!presetn)
    frame_done && wants_resp && typ_cmd |=> rtype_r == afc_pkg::TYPE_CMD_RSP
      && rlen_r == (has_param ? afc_pkg::RLEN_SET : afc_pkg::RLEN_QUERY))
    else $error("local command not answered correctly");
  a_bad_type_drop: assert property (@(posedge pclk) disable iff (!presetn)
    frame_done && cks_ok && !typ_tx && !typ_cmd
      |=> st_r == ST_SEARCH && cnt_type_r == 8'($past(cnt_type_r) + 8'h01))
    else $error("unsupported type not dropped and counted");
  a_esc_mode_apply: assert property (@(posedge pclk) disable iff (!presetn)
    param_set && cmd_r == afc_pkg::CMD_ESC_MODE |=> esc_mode_r == $past(pval_r[1:0]))
    else $error("parameter not applied at once");
  a_rx_stall_resp: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == ST_WAIT || st_r == ST_SEND |-> !rx_ready_r)
    else $error("receiver accepting bytes during a response");

endmodule : afc_codec

// File: src/afc_pkg.sv
package afc_pkg;

  // =====================================================================
  // frame layout
  localparam logic [7:0]  DELIM        = 8'h7e;
  localparam logic [7:0]  ESC_MARK     = 8'h7d;
  localparam logic [7:0]  ESC_XOR      = 8'h20;
  localparam logic [7:0]  XON_BYTE     = 8'h11;
  localparam logic [7:0]  XOFF_BYTE    = 8'h13;
  localparam logic [7:0]  CKSUM_BASE   = 8'hff;
  localparam logic [7:0]  TYPE_TX64    = 8'h00;
  localparam logic [7:0]  TYPE_CMD     = 8'h08;
  localparam logic [7:0]  TYPE_CMD_RSP = 8'h88;
  localparam logic [7:0]  TYPE_TX_STAT = 8'h89;
  localparam logic [63:0] BCAST_ADDR   = 64'h0000_0000_0000_ffff;
  localparam logic [1:0]  ESC_MODE_ON  = 2'h2;

  // body index, counted from the frame type byte
  localparam logic [15:0] BI_FID       = 16'h0001;
  localparam logic [15:0] BI_CMD_HI    = 16'h0002;
  localparam logic [15:0] BI_CMD_LO    = 16'h0003;
  localparam logic [15:0] BI_PARAM     = 16'h0004;
  localparam logic [15:0] BI_DEST_LAST = 16'h0009;
  localparam logic [15:0] BI_OPTS      = 16'h000a;
  localparam logic [15:0] BI_PAYLOAD   = 16'h000b;
  localparam logic [15:0] QUERY_LEN    = 16'h0004;

  // option bits
  localparam int OPT_NO_ACK     = 0;
  localparam int OPT_BCAST_PAN  = 2;

  // local commands with hardware meaning
  localparam logic [15:0] CMD_ESC_MODE    = 16'h4150;
  localparam logic [15:0] CMD_MAX_PAYLOAD = 16'h4e50;
  localparam logic [31:0] MAX_PAYLOAD     = 32'h0000_0100;

  // reply lengths (unescaped body bytes)
  localparam logic [3:0]  RLEN_TX_STAT = 4'h3;
  localparam logic [3:0]  RLEN_SET     = 4'h5;
  localparam logic [3:0]  RLEN_QUERY   = 4'h9;

  // =====================================================================
  // registers (byte addresses)
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STAT     = 8'h04;
  localparam logic [7:0]  REG_DEST_HI  = 8'h08;
  localparam logic [7:0]  REG_DEST_LO  = 8'h0c;
  localparam logic [7:0]  REG_TXINFO   = 8'h10;
  localparam logic [1:0]  CTRL_ESC_RST = 2'h0;
  localparam logic [7:0]  CTRL_TXS_RST = 8'h00;

  localparam int PMEM_DEPTH = 16;
  localparam int PMEM_AW    = 4;

  // =====================================================================
  typedef struct packed {
    logic [63:0] dest;
    logic [7:0]  opts;
    logic [15:0] plen;
  } afc_txreq_t;

  typedef struct packed {
    logic                en;
    logic [PMEM_AW-1:0]  addr;
    logic [31:0]         data;
  } afc_memwr_t;

  function automatic logic afc_needs_esc(input logic [7:0] b);
    return (b == DELIM) || (b == ESC_MARK) || (b == XON_BYTE) || (b == XOFF_BYTE);
  endfunction : afc_needs_esc

endpackage : afc_pkg

// File: src/afc_param_mem.sv
module afc_param_mem (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        clk_en,
  input  wire afc_pkg::afc_memwr_t         wr,
  input  wire logic [afc_pkg::PMEM_AW-1:0] rd_addr,
  output logic      [31:0]                 rd_data
);

  logic [31:0] mem_r [afc_pkg::PMEM_DEPTH];

  always_ff @(posedge pclk) begin
    if (clk_en && wr.en) begin
      mem_r[wr.addr] <= wr.data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= 32'h0000_0000;
    end else if (clk_en) begin
      rd_data <= mem_r[rd_addr];
    end
  end

endmodule : afc_param_mem

// File: src/afc_tx_escaper.sv
module afc_tx_escaper (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  input  wire logic       esc_on,
  input  wire logic [7:0] in_data,
  input  wire logic       in_first,
  input  wire logic       in_valid,
  output logic            in_ready,
  output logic      [7:0] out_data_r,
  output logic            out_valid_r,
  input  wire logic       out_ready
);

  logic       pend_r;
  logic [7:0] pend_data_r;
  logic       take;
  logic       stuff;

  assign in_ready = !out_valid_r;
  assign take     = clk_en && in_valid && in_ready;
  // the delimiter that opens a frame is never escaped
  assign stuff    = esc_on && !in_first && afc_pkg::afc_needs_esc(in_data);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_data_r  <= 8'h00;
      out_valid_r <= 1'b0;
      pend_r      <= 1'b0;
      pend_data_r <= 8'h00;
    end else if (clk_en) begin
      if (take) begin
        out_valid_r <= 1'b1;
        out_data_r  <= stuff ? afc_pkg::ESC_MARK : in_data;
        pend_r      <= stuff;
        pend_data_r <= in_data ^ afc_pkg::ESC_XOR;
      end else if (out_valid_r && out_ready) begin
        out_valid_r <= pend_r;
        out_data_r  <= pend_data_r;
        pend_r      <= 1'b0;
      end
    end
  end

  a_esc_stuff_pair: assert property (@(posedge pclk) disable iff (!presetn)
    take && stuff |=> out_data_r == afc_pkg::ESC_MARK && pend_r
      && pend_data_r == ($past(in_data) ^ afc_pkg::ESC_XOR))
    else $error("escape marker not emitted for a special byte");

endmodule : afc_tx_escaper

// File: verif/afc_host_model.sv
module afc_host_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  input  wire logic       slow,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==================================================
  // byte stream host: bench fills sq, replies land in rq
  logic [7:0] sq[$];
  logic [7:0] rq[$];
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  always @(posedge pclk) begin
    if (clk_en && tx_valid && tx_ready) rq.push_back(tx_data);
    if (clk_en && rx_valid && rx_ready) sq.delete(0);
    tx_ready <= presetn && (!slow || !tx_ready);
    rx_valid <= presetn && sq.size() > 0;
    // idle line shows a changing pattern, never a stale byte
    rx_data <= (sq.size() > 0) ? sq[0] : ~rx_data;
  end
endmodule : afc_host_model

// File: verif/tb_api_frame_command_codec.sv
module tb_api_frame_command_codec;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, er;
  logic        clk_en, escm;
  logic [7:0]  paddr, rx_data, tx_data;
  logic        rx_valid, rx_ready, tx_valid, tx_ready;
  logic [31:0] pwdata, prdata, rd;
  int          fails, n_compared;
  afc_codec uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  afc_host_model host (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .slow(slow),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
  // ==================================================
  // shared tasks
  task final_report();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(32'(n < 50), 32'h1);
    if (n >= 50) final_report();
    // let an idle edge pass so a following call never re-raises psel in this step
    @(posedge pclk);
  endtask : apb
  // delimiter, big-endian length and checksum on the unescaped body
  task mk(input logic [7:0] b[$], output logic [7:0] f[$]);
    logic [7:0]  s;
    logic [15:0] l;
    logic [7:0]  g[$];
    s = 8'h00;
    l = 16'(b.size());
    foreach (b[i]) s += b[i];
    f = {8'h7e, l[15:8], l[7:0], b, 8'hff - s};
    // escaped mode: stuff specials after the delimiter, length and sum included
    if (escm) begin
      g = {8'h7e};
      for (int i = 1; i < f.size(); i++) begin
        if (f[i] inside {8'h7e, 8'h7d, 8'h11, 8'h13}) g = {g, 8'h7d, f[i] ^ 8'h20};
        else g.push_back(f[i]);
      end
      f = g;
    end
  endtask : mk
  task send(input logic [7:0] b[$]);
    logic [7:0] f[$];
    mk(b, f);
    host.sq = {host.sq, f};
  endtask : send
  task expect_rsp(input logic [7:0] b[$]);
    logic [7:0] f[$];
    int         n;
    mk(b, f);
    n = 0;
    while (host.rq.size() < f.size() && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    check(32'(host.rq.size()), 32'(f.size()));
    if (n >= 3000) final_report();
    if (host.rq.size() == f.size()) foreach (f[i]) check(32'(host.rq[i]), 32'(f[i]));
    host.rq.delete();
  endtask : expect_rsp
  // ==================================================
  // scenarios
  task t_query();
    slow <= 1'b1;
    send('{8'h08, 8'h17, 8'h4e, 8'h50});
    expect_rsp('{8'h88, 8'h17, 8'h4e, 8'h50, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00});
    slow <= 1'b0;
    $display("query test done");
  endtask : t_query
  task t_set_get();
    send('{8'h08, 8'h21, 8'h41, 8'h42, 8'h12, 8'h34, 8'h56, 8'h78});
    expect_rsp('{8'h88, 8'h21, 8'h41, 8'h42, 8'h00});
    send('{8'h08, 8'h22, 8'h41, 8'h42});
    expect_rsp('{8'h88, 8'h22, 8'h41, 8'h42, 8'h00, 8'h12, 8'h34, 8'h56, 8'h78});
    $display("set and query test done");
  endtask : t_set_get
  task t_tx64();
    apb(1'b1, afc_pkg::REG_CTRL, 32'h0000_3300);
    host.sq.push_back(8'h55);
    // options keep the reserved bit clear
    send('{8'h00, 8'h52, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff,
      8'h05, 8'h54, 8'h78});
    expect_rsp('{8'h89, 8'h52, 8'h33});
    apb(1'b0, afc_pkg::REG_DEST_LO, 32'h0);
    check(rd, 32'h0000_ffff);
    apb(1'b0, afc_pkg::REG_DEST_HI, 32'h0);
    check(rd, 32'h0000_0000);
    apb(1'b0, afc_pkg::REG_TXINFO, 32'h0);
    check(rd, 32'h0002_0705);
    $display("transmit test done");
  endtask : t_tx64
  task t_drop();
    send('{8'h08, 8'h00, 8'h4e, 8'h50});
    host.sq = {host.sq, 8'h7e, 8'h00, 8'h04, 8'h08, 8'h33, 8'h4e, 8'h50, 8'h00};
    send('{8'h17, 8'h44, 8'h4e, 8'h50});
    repeat (80) @(posedge pclk);
    check(32'(host.rq.size()), 32'h0);
    apb(1'b0, afc_pkg::REG_STAT, 32'h0);
    check(rd, 32'h0001_0105);
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, er}, 32'h1);
    $display("drop test done");
  endtask : t_drop
  task t_freeze();
    clk_en <= 1'b0;
    send('{8'h08, 8'h31, 8'h4e, 8'h50});
    repeat (30) @(posedge pclk);
    check(32'(host.rq.size()), 32'h0);
    check({31'h0, rx_ready}, 32'h1);
    clk_en <= 1'b1;
    expect_rsp('{8'h88, 8'h31, 8'h4e, 8'h50, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00});
    $display("clock enable test done");
  endtask : t_freeze
  task t_escaped();
    send('{8'h08, 8'h05, 8'h41, 8'h50, 8'h00, 8'h00, 8'h00, 8'h02});
    expect_rsp('{8'h88, 8'h05, 8'h41, 8'h50, 8'h00});
    apb(1'b0, afc_pkg::REG_CTRL, 32'h0);
    check(rd, 32'h0000_3302);
    escm = 1'b1;
    send('{8'h08, 8'h7e, 8'h41, 8'h50});
    expect_rsp('{8'h88, 8'h7e, 8'h41, 8'h50, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02});
    $display("escaped mode test done");
  endtask : t_escaped
  // ==================================================
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    slow = 1'b0;
    clk_en = 1'b1;
    escm = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_query();
    t_set_get();
    t_tx64();
    t_drop();
    t_freeze();
    t_escaped();
    final_report();
  end
  initial begin
    #400000;
    fails++;
    final_report();
  end
endmodule : tb_api_frame_command_codec
